// >>> src/pmsc_pkg.sv
// constants, types and register map for the power management status and control block
package pmsc_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam logic [3:0] ADDR_POWER_STATUS_CONTROL_TWO = 4'h0;
	localparam logic [3:0] ADDR_SYSTEM_OPTIONS_TWO = 4'h1;
	localparam logic [3:0] ADDR_IRQ_STATUS = 4'h2;
	localparam logic [3:0] ADDR_IRQ_CLEAR = 4'h3;
	localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h4;
	// power status register fields
	localparam int BIT_WARNING_FLAG = 7;
	localparam int BIT_WARNING_ACK = 6;
	localparam int BIT_DETECT_VSEL = 5;
	localparam int BIT_WARNING_VSEL = 4;
	localparam int BIT_PPD_FLAG = 3;
	localparam int BIT_PPD_ACK = 2;
	localparam int BIT_STOP_MODE_SEL = 0;
	// system options field
	localparam int BIT_WATCHDOG_CLK_SEL = 0;
	// interrupt fields
	localparam int BIT_IRQ_WARNING = 0;
	localparam int BIT_IRQ_PPD = 1;
	localparam int IRQ_W = 2;
	localparam logic [7:0] RESET_POWER_STATUS = 8'h00;
	localparam logic [7:0] RESET_OPTIONS = 8'h00;
	localparam logic [1:0] RESET_IRQ = 2'h0;
	localparam int SYNC_STAGES = 3;

	typedef enum logic [1:0] {
		RST_POWER_ON = 2'b00,
		RST_LOW_VOLTAGE = 2'b01,
		RST_OTHER = 2'b10
	} reset_cause_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} bus_req_t;

	typedef struct packed {
		logic detect_voltage_select;
		logic warning_voltage_select;
		logic stop_mode_select;
		logic watchdog_clk_select;
	} ctrl_out_t;
endpackage

// >>> src/pmsc_sync.sv
// three-stage synchroniser with agreement of the last two stages
`timescale 1ns/100ps
`default_nettype none
module pmsc_sync
	import pmsc_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_async,
	output logic o_level
);
	logic [SYNC_STAGES-1:0] stage;
	logic [SYNC_STAGES-1:0] next_stage;
	logic level;
	logic next_level;

	always_comb
	begin
		next_stage = {stage[SYNC_STAGES-2:0], i_async};
		next_level = level;
		// first stage feeds only the second
		if (stage[1] == stage[2])
		begin
			next_level = stage[2];
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			stage <= '0;
			level <= 1'b0;
		end
		else
		begin
			stage <= next_stage;
			level <= next_level;
		end
	end

	assign o_level = level;
endmodule
`default_nettype wire

// >>> src/pmsc_write_once.sv
// write-once bit: takes the first write after reset, ignores the rest
`timescale 1ns/100ps
`default_nettype none
module pmsc_write_once
	import pmsc_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_wr,
	input wire logic i_wdata,
	output logic o_value
);
	logic value;
	logic used;
	logic next_value;
	logic next_used;

	always_comb
	begin
		next_value = value;
		next_used = used;
		if (i_wr && !used)
		begin
			next_value = i_wdata;
			next_used = 1'b1;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			value <= 1'b0;
			used <= 1'b0;
		end
		else
		begin
			value <= next_value;
			used <= next_used;
		end
	end

	assign o_value = value;
endmodule
`default_nettype wire

// >>> src/power_mgmt_status_control.sv
// power management status and control register bank
//
// Operation
// RL1 - the warning flag is set when supply drops below the warning trip, and after reset if already below.
// RL2 - the warning flag is sticky: it reads 1 while a warning exists or has existed since last cleared.
// RL3 - writing 1 to the warning acknowledge clears the flag only when no warning is present; it reads 0.
// RL4 - the detect voltage select picks the low (0) or high (1) detect trip point for the comparator.
// RL5 - the warning voltage select picks the low (0) or high (1) warning trip point.
// RL6 - the partial power down flag is set on wake from partial power down stop, else reads 0.
// RL7 - writing 1 to the partial power down acknowledge clears that flag; it reads 0.
// RL8 - the stop mode select chooses state retaining stop (0) or partial power down stop (1).
// RL9 - the stop mode select takes only the first write after any reset.
// RL10 - the watchdog clock select is write-once; 0 picks the 1 kHz clock, 1 the bus clock.
// RL11 - power-on reset clears every bit; other resets keep the two trip point selects.
`timescale 1ns/100ps
`default_nettype none
module power_mgmt_status_control
	import pmsc_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire pmsc_pkg::reset_cause_t i_reset_cause,
	input wire pmsc_pkg::bus_req_t i_bus,
	input wire logic i_warning_below,
	input wire logic i_ppd_wake,
	output logic [pmsc_pkg::DATA_W-1:0] o_rdata,
	output pmsc_pkg::ctrl_out_t o_ctrl,
	output logic o_irq
);
	import pmsc_pkg::*;

	function automatic logic wr_hit(input bus_req_t b, input logic [ADDR_W-1:0] a);
		wr_hit = b.wr && (b.addr == a);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	logic below_sync;
	logic below_q;
	logic warning_flag;
	logic ppd_flag;
	logic ppd_wake_q;
	logic detect_voltage_select;
	logic warning_voltage_select;
	logic stop_mode_select;
	logic watchdog_clk_select;
	logic first_cycle;
	logic [IRQ_W-1:0] irq_status;
	logic [IRQ_W-1:0] irq_enable;
	logic [DATA_W-1:0] rdata;
	logic irq;
	ctrl_out_t ctrl;
	logic next_warning_flag;
	logic next_ppd_flag;
	logic next_detect_voltage_select;
	logic next_warning_voltage_select;
	logic [IRQ_W-1:0] next_irq_status;
	logic [IRQ_W-1:0] next_irq_enable;
	logic [DATA_W-1:0] next_rdata;
	logic next_irq;
	ctrl_out_t next_ctrl;
	logic wr_psc;
	logic wr_opt;
	logic warning_rise;
	logic ppd_rise;

	// comparator outputs are analog-side levels, so synchronise them
	pmsc_sync u_sync_below (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_async(i_warning_below),
		.o_level(below_sync)
	);

	pmsc_sync u_sync_wake (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_async(i_ppd_wake),
		.o_level(ppd_wake_q)
	);

	assign wr_psc = wr_hit(i_bus, ADDR_POWER_STATUS_CONTROL_TWO);
	assign wr_opt = wr_hit(i_bus, ADDR_SYSTEM_OPTIONS_TWO);

	// RL9 stop mode once
	pmsc_write_once u_stop_mode (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_wr(wr_psc),
		.i_wdata(i_bus.wdata[BIT_STOP_MODE_SEL]),
		.o_value(stop_mode_select)
	);

	// RL10 watchdog clock once
	pmsc_write_once u_watchdog_clk (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_wr(wr_opt),
		.i_wdata(i_bus.wdata[BIT_WATCHDOG_CLK_SEL]),
		.o_value(watchdog_clk_select)
	);

	////////////////////////////////////////////////////////////////////////////////
	// status flags
	always_comb
	begin
		// RL1 warning set
		// first_cycle term never fires, as below_sync is still 0 then; the rise over below_q catches a supply already low
		warning_rise = (below_sync && !below_q) || (first_cycle && below_sync);
		ppd_rise = ppd_wake_q && !ppd_flag;
		next_warning_flag = warning_flag;
		next_ppd_flag = ppd_flag;
		// RL3 acknowledge gated
		if (wr_psc && i_bus.wdata[BIT_WARNING_ACK] && !below_sync)
		begin
			next_warning_flag = 1'b0;
		end
		// RL2 sticky hold
		if (warning_rise || below_sync)
		begin
			next_warning_flag = 1'b1;
		end
		// RL7 acknowledge clears
		if (wr_psc && i_bus.wdata[BIT_PPD_ACK])
		begin
			next_ppd_flag = 1'b0;
		end
		// RL6 wake sets, wins over clear
		// set from the level, so an acknowledge during the wake cannot drop it
		if (ppd_wake_q)
		begin
			next_ppd_flag = 1'b1;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			warning_flag <= 1'b0;
			ppd_flag <= 1'b0;
			below_q <= 1'b0;
			first_cycle <= 1'b1;
		end
		else
		begin
			warning_flag <= next_warning_flag;
			ppd_flag <= next_ppd_flag;
			below_q <= below_sync;
			first_cycle <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// trip point selects survive non power-on resets, so they use no async reset
	always_comb
	begin
		next_detect_voltage_select = detect_voltage_select;
		next_warning_voltage_select = warning_voltage_select;
		// a write may come on the first edge after release, so it wins over the clear
		if (wr_psc)
		begin
			// RL4 detect select
			next_detect_voltage_select = i_bus.wdata[BIT_DETECT_VSEL];
			// RL5 warning select
			next_warning_voltage_select = i_bus.wdata[BIT_WARNING_VSEL];
		end
		// RL11 power-on clears
		else if (first_cycle && i_reset_cause == RST_POWER_ON)
		begin
			next_detect_voltage_select = 1'b0;
			next_warning_voltage_select = 1'b0;
		end
	end

	always_ff @(posedge i_ref_clk)
	begin
		detect_voltage_select <= next_detect_voltage_select;
		warning_voltage_select <= next_warning_voltage_select;
	end

	////////////////////////////////////////////////////////////////////////////////
	// interrupts
	always_comb
	begin
		next_irq_status = irq_status;
		next_irq_enable = irq_enable;
		if (wr_hit(i_bus, ADDR_IRQ_CLEAR))
		begin
			next_irq_status = irq_status & ~i_bus.wdata[IRQ_W-1:0];
		end
		if (wr_hit(i_bus, ADDR_IRQ_ENABLE))
		begin
			next_irq_enable = i_bus.wdata[IRQ_W-1:0];
		end
		// events set after the clear so a same-cycle event survives
		if (warning_rise)
		begin
			next_irq_status[BIT_IRQ_WARNING] = 1'b1;
		end
		if (ppd_rise)
		begin
			next_irq_status[BIT_IRQ_PPD] = 1'b1;
		end
		// built from next values so the output flop shows no extra lag
		next_irq = |(next_irq_status & next_irq_enable);
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			irq_status <= RESET_IRQ;
			irq_enable <= RESET_IRQ;
			irq <= 1'b0;
		end
		else
		begin
			irq_status <= next_irq_status;
			irq_enable <= next_irq_enable;
			irq <= next_irq;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read data, zero on every cycle without a read
	always_comb
	begin
		next_rdata = '0;
		if (i_bus.rd)
		begin
			unique case (i_bus.addr)
				ADDR_POWER_STATUS_CONTROL_TWO:
				begin
					// acknowledge bits read as zero
					next_rdata[BIT_WARNING_FLAG] = warning_flag;
					next_rdata[BIT_DETECT_VSEL] = detect_voltage_select;
					next_rdata[BIT_WARNING_VSEL] = warning_voltage_select;
					next_rdata[BIT_PPD_FLAG] = ppd_flag;
					next_rdata[BIT_STOP_MODE_SEL] = stop_mode_select;
				end
				ADDR_SYSTEM_OPTIONS_TWO:
				begin
					next_rdata[BIT_WATCHDOG_CLK_SEL] = watchdog_clk_select;
				end
				ADDR_IRQ_STATUS:
				begin
					next_rdata[IRQ_W-1:0] = irq_status;
				end
				ADDR_IRQ_ENABLE:
				begin
					next_rdata[IRQ_W-1:0] = irq_enable;
				end
				// the clear register is write only, so it lands here and reads zero
				default:
				begin
					next_rdata = '0;
				end
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			rdata <= '0;
		end
		else
		begin
			rdata <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// control outputs, registered so every port leaves a flop
	always_comb
	begin
		// RL4 to comparator
		next_ctrl.detect_voltage_select = detect_voltage_select;
		next_ctrl.warning_voltage_select = warning_voltage_select;
		// RL8 stop mode out
		next_ctrl.stop_mode_select = stop_mode_select;
		next_ctrl.watchdog_clk_select = watchdog_clk_select;
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			ctrl <= '0;
		end
		else
		begin
			ctrl <= next_ctrl;
		end
	end

	assign o_rdata = rdata;
	assign o_ctrl = ctrl;
	assign o_irq = irq;
endmodule
`default_nettype wire

// >>> testbench/power_mgmt_status_control_assertions.sv
// checker for the power management status and control block
`timescale 1ns/100ps
`default_nettype none
module pmsc_checker
	import pmsc_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire pmsc_pkg::bus_req_t i_bus,
	input wire logic i_warning_below,
	input wire logic i_ppd_wake,
	input wire logic [pmsc_pkg::DATA_W-1:0] o_rdata,
	input wire pmsc_pkg::ctrl_out_t o_ctrl,
	input wire logic o_irq
);
	logic w0;
	logic w1;
	logic r0;
	logic d0;
	logic d1;
	assign w0 = i_bus.wr && i_bus.addr == ADDR_POWER_STATUS_CONTROL_TWO;
	assign w1 = i_bus.wr && i_bus.addr == ADDR_SYSTEM_OPTIONS_TWO;
	assign r0 = i_bus.rd && i_bus.addr == ADDR_POWER_STATUS_CONTROL_TWO;
	// set once a write-once bit has had its one write
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			d0 <= 1'b0;
			d1 <= 1'b0;
		end
		else
		begin
			d0 <= d0 | w0;
			d1 <= d1 | w1;
		end
	end
	////////////////////////////////////////////////////////////
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rst_n);
	// six cycles leave room for the input synchroniser
	property p_warn_set;
		i_warning_below[*6] ##1 r0 |=> o_rdata[BIT_WARNING_FLAG];
	endproperty
	a_warn_set: assert property (p_warn_set)
		else $error("warning flag not set");
	property p_warn_clr;
		!i_warning_below[*6] ##1 (w0 && i_bus.wdata[BIT_WARNING_ACK]) ##2 r0
			|=> !o_rdata[BIT_WARNING_FLAG];
	endproperty
	a_warn_clr: assert property (p_warn_clr)
		else $error("warning flag not cleared");
	property p_ppd_set;
		i_ppd_wake[*6] ##1 r0 |=> o_rdata[BIT_PPD_FLAG];
	endproperty
	a_ppd_set: assert property (p_ppd_set)
		else $error("ppd flag not set");
	property p_ppd_clr;
		!i_ppd_wake[*6] ##1 (w0 && i_bus.wdata[BIT_PPD_ACK]) ##2 r0 |=> !o_rdata[BIT_PPD_FLAG];
	endproperty
	a_ppd_clr: assert property (p_ppd_clr)
		else $error("ppd flag not cleared");
	property p_sel;
		w0 |-> ##2 o_ctrl.detect_voltage_select == $past(i_bus.wdata[BIT_DETECT_VSEL], 2)
			&& o_ctrl.warning_voltage_select == $past(i_bus.wdata[BIT_WARNING_VSEL], 2);
	endproperty
	a_sel: assert property (p_sel)
		else $error("trip select wrong");
	property p_stop_first;
		w0 && !d0 |-> ##2 o_ctrl.stop_mode_select == $past(i_bus.wdata[BIT_STOP_MODE_SEL], 2);
	endproperty
	a_stop_first: assert property (p_stop_first)
		else $error("stop select not taken");
	property p_stop_once;
		w0 && d0 |-> ##2 $stable(o_ctrl.stop_mode_select);
	endproperty
	a_stop_once: assert property (p_stop_once)
		else $error("stop select rewritten");
	property p_wdog_once;
		w1 && d1 |-> ##2 $stable(o_ctrl.watchdog_clk_select);
	endproperty
	a_wdog_once: assert property (p_wdog_once)
		else $error("watchdog select rewritten");
	c_warn: cover property (r0 ##1 o_rdata[BIT_WARNING_FLAG]);
	c_ppd: cover property (r0 ##1 o_rdata[BIT_PPD_FLAG]);
	c_irq: cover property (o_irq);
endmodule
bind power_mgmt_status_control pmsc_checker u_pmsc_checker (
	.i_ref_clk(i_ref_clk),
	.i_rst_n(i_rst_n),
	.i_bus(i_bus),
	.i_warning_below(i_warning_below),
	.i_ppd_wake(i_ppd_wake),
	.o_rdata(o_rdata),
	.o_ctrl(o_ctrl),
	.o_irq(o_irq)
);
`default_nettype wire

// >>> testbench/tb_power_mgmt_status_control.sv
// bench for the power management status and control block
`timescale 1ns/100ps
`default_nettype none
module tb_power_mgmt_status_control;
	import pmsc_pkg::*;
	localparam logic [3:0] PS = ADDR_POWER_STATUS_CONTROL_TWO;
	localparam logic [3:0] OPT = ADDR_SYSTEM_OPTIONS_TWO;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	reset_cause_t cause = RST_POWER_ON;
	bus_req_t bus = '0;
	logic below = 1'b0;
	logic wake = 1'b0;
	logic [7:0] rdata;
	ctrl_out_t ctrl;
	logic irq;
	int mismatches = 0;
	int checks = 0;
	power_mgmt_status_control u_power_mgmt_status_control (
		.i_ref_clk(clk),
		.i_rst_n(rst_n),
		.i_reset_cause(cause),
		.i_bus(bus),
		.i_warning_below(below),
		.i_ppd_wake(wake),
		.o_rdata(rdata),
		.o_ctrl(ctrl),
		.o_irq(irq)
	);
	always #50 clk = ~clk;
	////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus <= '0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus <= '0;
		#10;
		chk(rdata, exp);
	endtask
	// the interrupt output is registered, so give it two edges
	task automatic irq_is(input logic e);
		repeat (2) @(posedge clk);
		#10;
		chk({7'h00, irq}, {7'h00, e});
	endtask
	task automatic rst(input reset_cause_t c);
		@(posedge clk);
		rst_n <= 1'b0;
		cause <= c;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
	endtask
	task automatic complete_run;
		if (mismatches == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		#100000;
		mismatches++;
		complete_run();
	end
	initial
	begin
		rst(RST_POWER_ON);
		rd(PS, 8'h00);
		rd(OPT, 8'h00);
		rd(4'hF, 8'h00);
		wr(PS, 8'h31);
		repeat (2) @(posedge clk);
		#10 chk({4'h0, ctrl}, 8'h0E);
		rd(PS, 8'h31);
		wr(PS, 8'h00);
		rd(PS, 8'h01);
		wr(PS, 8'h30);
		wr(OPT, 8'h01);
		wr(OPT, 8'h00);
		rd(OPT, 8'h01);
		chk({4'h0, ctrl}, 8'h0F);
		wr(ADDR_IRQ_ENABLE, 8'h02);
		@(posedge clk) below <= 1'b1;
		repeat (6) @(posedge clk);
		rd(PS, 8'hB1);
		rd(ADDR_IRQ_STATUS, 8'h01);
		irq_is(1'b0);
		wr(ADDR_IRQ_ENABLE, 8'h03);
		irq_is(1'b1);
		wr(PS, 8'h70);
		rd(PS, 8'hB1);
		@(posedge clk) below <= 1'b0;
		repeat (6) @(posedge clk);
		rd(PS, 8'hB1);
		wr(PS, 8'h70);
		rd(PS, 8'h31);
		wr(ADDR_IRQ_CLEAR, 8'h01);
		irq_is(1'b0);
		@(posedge clk) wake <= 1'b1;
		repeat (6) @(posedge clk);
		rd(PS, 8'h39);
		@(posedge clk) wake <= 1'b0;
		irq_is(1'b1);
		repeat (6) @(posedge clk);
		wr(PS, 8'h34);
		rd(PS, 8'h31);
		wr(ADDR_IRQ_CLEAR, 8'h02);
		rd(ADDR_IRQ_STATUS, 8'h00);
		@(posedge clk) below <= 1'b1;
		rst(RST_LOW_VOLTAGE);
		repeat (6) @(posedge clk);
		rd(PS, 8'hB0);
		@(posedge clk) below <= 1'b0;
		rst(RST_OTHER);
		rd(PS, 8'h30);
		wr(PS, 8'h31);
		rd(PS, 8'h31);
		rst(RST_POWER_ON);
		rd(PS, 8'h00);
		complete_run();
	end
endmodule
`default_nettype wire
